// ---- hw/eprom_array.sv ----
`include "eprom_ctl_defines.svh"
module eprom_array
	import eprom_ctl_pkg::*;
(
	// clock
	input wire logic sys_clk,
	// read port
	input wire array_index_t rdIndex,
	output eprom_byte_t rdData,
	// burn port
	input wire logic burnEn,
	input wire array_index_t burnIndex,
	input wire eprom_byte_t burnData
);
	// two-state cells come up all zero, the erased value
	// no reset reaches them, so contents survive any reset
	bit [7:0] cells [`ARRAY_DEPTH];
	// or-in only: a burned one can never return to zero
	always_ff @(posedge sys_clk) begin
		if (burnEn) begin
			cells[burnIndex] <= cells[burnIndex] | burnData;
		end
	end
	assign rdData = cells[rdIndex];
endmodule

// ---- hw/eprom_ctl.sv ----
`include "eprom_ctl_defines.svh"
module eprom_ctl
	import eprom_ctl_pkg::*;
(
	// clock and reset
	input wire logic sys_clk,
	input wire logic resetn,
	// axi4-lite write address
	input wire logic [17:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	// axi4-lite write data
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	// axi4-lite write response
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// axi4-lite read address
	input wire logic [17:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	// axi4-lite read data
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// cpu core signals
	input wire logic stopEntry,
	input wire logic arraySupplyPin,
	output logic vectorFetchAllow,
	output logic bootRomAllow,
	output logic readMode
);
	logic latchEnable_r;
	logic programEnable_r;
	logic supplyMeta_r;
	logic supplySync_r;
	logic [10:0] groupAddr_r;
	eprom_byte_t groupData_r [16];
	logic [15:0] groupValid_r;
	burn_state_t burnState_r;
	logic [3:0] burnSlot_r;
	logic burned_r;
	logic [17:0] awAddr_r;
	logic awHeld_r;
	logic [31:0] wData_r;
	logic [3:0] wStrb_r;
	logic wHeld_r;
	logic [17:0] arAddr_r;
	logic rdPending_r;
	array_mode_t mode;
	array_map_t wrMap;
	array_map_t rdMap;
	eprom_addr_t wrEprom;
	logic doWrite;
	logic ctrlWrite;
	logic arrayWrite;
	logic burnEn;
	array_index_t burnIndex;
	array_map_t burnMap;
	eprom_byte_t arrayByte;
	logic wrMapped;

	// control pair decode
	always_comb begin
		if (!latchEnable_r) begin
			mode = MODE_READ;
		end else if (!programEnable_r) begin
			mode = MODE_LOAD;
		end else begin
			mode = MODE_PROGRAM;
		end
	end

	// supply level comes from a pin, so two flops before use
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			supplyMeta_r <= 1'b0;
			supplySync_r <= 1'b0;
		end else begin
			supplyMeta_r <= arraySupplyPin;
			supplySync_r <= supplyMeta_r;
		end
	end

	// write side decode, array window is one word per eprom byte
	assign wrEprom = awAddr_r[16:2];
	assign wrMap = mapAddr(wrEprom);
	assign doWrite = awHeld_r && wHeld_r && !s_axi_bvalid;
	assign ctrlWrite = doWrite && awAddr_r == `CTRL_OFFSET && wStrb_r[0];
	assign arrayWrite = doWrite && awAddr_r <= `ARRAY_WIN_TOP && awAddr_r[1:0] == 2'b00;
	assign wrMapped = arrayWrite && wrMap.hit;

	// address and data channels taken in either order
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			awHeld_r <= 1'b0;
			awAddr_r <= '0;
			s_axi_awready <= 1'b1;
		end else if (s_axi_awvalid && s_axi_awready) begin
			awHeld_r <= 1'b1;
			awAddr_r <= s_axi_awaddr;
			s_axi_awready <= 1'b0;
		end else if (s_axi_bvalid && s_axi_bready) begin
			awHeld_r <= 1'b0;
			s_axi_awready <= 1'b1;
		end
	end

	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			wHeld_r <= 1'b0;
			wData_r <= '0;
			wStrb_r <= '0;
			s_axi_wready <= 1'b1;
		end else if (s_axi_wvalid && s_axi_wready) begin
			wHeld_r <= 1'b1;
			wData_r <= s_axi_wdata;
			wStrb_r <= s_axi_wstrb;
			s_axi_wready <= 1'b0;
		end else if (s_axi_bvalid && s_axi_bready) begin
			wHeld_r <= 1'b0;
			s_axi_wready <= 1'b1;
		end
	end

	// response once both halves are in; unmapped words answer slverr
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= `RESP_OKAY;
		end else if (doWrite) begin
			s_axi_bvalid <= 1'b1;
			if (wrMapped || awAddr_r == `CTRL_OFFSET || awAddr_r == `STATUS_OFFSET) begin
				s_axi_bresp <= `RESP_OKAY;
			end else begin
				s_axi_bresp <= `RESP_SLVERR;
			end
		end else if (s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
	end

	// latch enable: software sets or clears, stop clears it
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			latchEnable_r <= 1'b0;
		end else if (stopEntry) begin
			latchEnable_r <= 1'b0;
		end else if (ctrlWrite) begin
			latchEnable_r <= wData_r[`CTRL_LATCH_BIT];
		end
	end

	// program enable: set only after a captured byte, cleared by a write only when it clears latch
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			programEnable_r <= 1'b0;
		end else if (!latchEnable_r || stopEntry
			|| (ctrlWrite && !wData_r[`CTRL_LATCH_BIT])) begin
			// falls with latch in the same edge, never outlives it
			programEnable_r <= 1'b0;
		end else if (ctrlWrite && wData_r[`CTRL_PROGRAM_BIT] && wData_r[`CTRL_LATCH_BIT]
			&& groupValid_r != 16'h0000) begin
			programEnable_r <= 1'b1;
		end
	end

	// group latches: first byte fixes the upper address, others must match
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			groupAddr_r <= '0;
			groupValid_r <= '0;
			for (int i = 0; i < 16; i++) begin
				groupData_r[i] <= `ERASED_BYTE;
			end
		end else if (mode == MODE_READ) begin
			groupValid_r <= '0;
		end else if (mode == MODE_LOAD && wrMapped && wStrb_r[0]) begin
			if (groupValid_r == 16'h0000 || groupAddr_r == wrEprom[14:4]) begin
				groupAddr_r <= wrEprom[14:4];
				groupValid_r[wrEprom[3:0]] <= 1'b1;
				groupData_r[wrEprom[3:0]] <= wData_r[7:0];
			end
		end
	end

	// burn walks the sixteen slots once the supply is seen at level
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			burnState_r <= BURN_IDLE;
			burnSlot_r <= '0;
			burned_r <= 1'b0;
		end else if (mode != MODE_PROGRAM) begin
			burnState_r <= BURN_IDLE;
			burnSlot_r <= '0;
			if (mode == MODE_LOAD && ctrlWrite) begin
				burned_r <= 1'b0;
			end
		end else begin
			unique case (burnState_r)
				BURN_IDLE: begin
					if (supplySync_r) begin
						burnState_r <= BURN_RUN;
					end
				end
				BURN_RUN: begin
					burnSlot_r <= burnSlot_r + 4'h1;
					if (burnSlot_r == 4'hf) begin
						burnState_r <= BURN_DONE;
						burned_r <= 1'b1;
					end
				end
				BURN_DONE: begin
					burnState_r <= BURN_DONE;
				end
			endcase
		end
	end

	assign burnMap = mapAddr({groupAddr_r, burnSlot_r});
	assign burnIndex = burnMap.index;
	assign burnEn = mode == MODE_PROGRAM && burnState_r == BURN_RUN
		&& groupValid_r[burnSlot_r] && burnMap.hit;

	// storage; reset never reaches it
	eprom_array u_array (
		.sys_clk(sys_clk),
		.rdIndex(rdMap.index),
		.rdData(arrayByte),
		.burnEn(burnEn),
		.burnIndex(burnIndex),
		.burnData(groupData_r[burnSlot_r])
	);

	// read side: one read at a time, answered the cycle after address
	assign rdMap = mapAddr(arAddr_r[16:2]);
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			arAddr_r <= '0;
			rdPending_r <= 1'b0;
			s_axi_arready <= 1'b1;
		end else if (s_axi_arvalid && s_axi_arready) begin
			arAddr_r <= s_axi_araddr;
			rdPending_r <= 1'b1;
			s_axi_arready <= 1'b0;
		end else if (rdPending_r) begin
			rdPending_r <= 1'b0;
		end else if (s_axi_rvalid && s_axi_rready) begin
			s_axi_arready <= 1'b1;
		end
	end

	// latched reads return erased value, never trust them
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= '0;
			s_axi_rresp <= `RESP_OKAY;
		end else if (rdPending_r) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rresp <= `RESP_OKAY;
			s_axi_rdata <= '0;
			if (arAddr_r == `CTRL_OFFSET) begin
				s_axi_rdata[`CTRL_LATCH_BIT] <= latchEnable_r;
				s_axi_rdata[`CTRL_PROGRAM_BIT] <= programEnable_r;
			end else if (arAddr_r == `STATUS_OFFSET) begin
				s_axi_rdata[`STS_CAPTURED_BIT] <= groupValid_r != 16'h0000;
				s_axi_rdata[`STS_BURNED_BIT] <= burned_r;
				s_axi_rdata[`STS_SUPPLY_BIT] <= supplySync_r;
				s_axi_rdata[`STS_BURNING_BIT] <= burnState_r == BURN_RUN;
			end else if (arAddr_r <= `ARRAY_WIN_TOP && arAddr_r[1:0] == 2'b00
				&& rdMap.hit) begin
				// regions map option and vectors apart
				s_axi_rdata[7:0] <= latchEnable_r ? `ERASED_BYTE : arrayByte;
			end else begin
				s_axi_rresp <= `RESP_SLVERR;
			end
		end else if (s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end

	// cpu may fetch vectors or run boot code only in read mode
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			vectorFetchAllow <= 1'b1;
			bootRomAllow <= 1'b1;
			readMode <= 1'b1;
		end else begin
			vectorFetchAllow <= !latchEnable_r && !stopEntry;
			bootRomAllow <= !latchEnable_r && !stopEntry;
			readMode <= !latchEnable_r && !stopEntry;
		end
	end

	// length of the current burn run, only for the checks below
	logic [4:0] runLen_r;
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			runLen_r <= 5'h00;
		end else if (burnState_r == BURN_RUN) begin
			runLen_r <= runLen_r + 5'h01;
		end else begin
			runLen_r <= 5'h00;
		end
	end

	// checks
	property p_pgm_needs_latch;
		@(posedge sys_clk) disable iff (!resetn) programEnable_r |-> latchEnable_r;
	endproperty
	a_pgm_needs_latch: assert property (p_pgm_needs_latch) else $error("program without latch");
	property p_pgm_needs_byte;
		@(posedge sys_clk) disable iff (!resetn)
		$rose(programEnable_r) |-> $past(groupValid_r) != 16'h0000;
	endproperty
	a_pgm_needs_byte: assert property (p_pgm_needs_byte) else $error("program with no byte");
	property p_pgm_no_sw_clear;
		@(posedge sys_clk) disable iff (!resetn)
		$fell(programEnable_r) |-> !$past(latchEnable_r) || $past(stopEntry) || !latchEnable_r;
	endproperty
	a_pgm_no_sw_clear: assert property (p_pgm_no_sw_clear) else $error("program cleared by write");
	property p_stop_clears;
		@(posedge sys_clk) disable iff (!resetn) stopEntry |=> !latchEnable_r && !programEnable_r;
	endproperty
	a_stop_clears: assert property (p_stop_clears) else $error("stop left latch set");
	property p_vector_block;
		@(posedge sys_clk) disable iff (!resetn) latchEnable_r |=> !vectorFetchAllow && !bootRomAllow;
	endproperty
	a_vector_block: assert property (p_vector_block) else $error("fetch allowed while latched");
	property p_burn_after_supply;
		@(posedge sys_clk) disable iff (!resetn)
		$rose(burnState_r == BURN_RUN) |-> $past(supplySync_r) && $past(programEnable_r);
	endproperty
	a_burn_after_supply: assert property (p_burn_after_supply) else $error("burn out of mode");
	property p_burn_sixteen;
		@(posedge sys_clk) disable iff (!resetn)
		burnState_r == BURN_DONE && runLen_r != 5'h00 |-> runLen_r == 5'h10;
	endproperty
	a_burn_sixteen: assert property (p_burn_sixteen) else $error("burn length wrong");
	property p_burn_bounded;
		@(posedge sys_clk) disable iff (!resetn) burnState_r == BURN_RUN |-> runLen_r < 5'h10;
	endproperty
	a_burn_bounded: assert property (p_burn_bounded) else $error("burn ran too long");
	property p_latched_read_blank;
		@(posedge sys_clk) disable iff (!resetn)
		rdPending_r && latchEnable_r && arAddr_r <= `ARRAY_WIN_TOP |=> s_axi_rdata[7:0] == 8'h00;
	endproperty
	a_latched_read_blank: assert property (p_latched_read_blank) else $error("latched read data");
	property p_load_no_burn;
		@(posedge sys_clk) disable iff (!resetn) mode == MODE_LOAD |-> !burnEn;
	endproperty
	a_load_no_burn: assert property (p_load_no_burn) else $error("array altered in load");
endmodule

// ---- pkg/eprom_ctl_defines.svh ----
// Summary of operation
// - main array 0x0400 to 0x7dff, 31232 bytes
// - top sixteen bytes hold the vectors
// - option byte sits alone at 0x7fde
// - clearing latch enable clears program enable
// - array reads while latched are not valid
// - no vector fetch while latch enable set
// - no boot routines while latch enable set
// - stop entry forces plain read mode
// - erased byte reads back as 0x00
// - programming only ever adds one bits
// - up to sixteen bytes, one address group
// - reset leaves option byte and array alone
// - program enable needs latch and a byte
// - stop and resets clear latch enable
// - control pair decodes read, load, program
`ifndef EPROM_CTL_DEFINES_SVH
`define EPROM_CTL_DEFINES_SVH
`define MAIN_FIRST 15'h0400
`define MAIN_LAST 15'h7dff
`define MAIN_BYTES 15'h7a00
`define OPTION_ADDR 15'h7fde
`define VECTOR_FIRST 15'h7ff0
`define ARRAY_DEPTH 31249
`define ERASED_BYTE 8'h00
`define ARRAY_WIN_TOP 18'h1fffc
`define CTRL_OFFSET 18'h20000
`define STATUS_OFFSET 18'h20004
`define CTRL_LATCH_BIT 0
`define CTRL_PROGRAM_BIT 1
`define STS_CAPTURED_BIT 0
`define STS_BURNED_BIT 1
`define STS_SUPPLY_BIT 2
`define STS_BURNING_BIT 3
`define RESP_OKAY 2'b00
`define RESP_SLVERR 2'b10
`endif

// ---- pkg/eprom_ctl_pkg.sv ----
`include "eprom_ctl_defines.svh"
package eprom_ctl_pkg;
	typedef logic [14:0] eprom_addr_t;
	typedef logic [14:0] array_index_t;
	typedef logic [7:0] eprom_byte_t;
	typedef enum logic [1:0] {
		MODE_READ,
		MODE_LOAD,
		MODE_PROGRAM
	} array_mode_t;
	typedef enum logic [1:0] {
		BURN_IDLE,
		BURN_RUN,
		BURN_DONE
	} burn_state_t;
	typedef struct packed {
		logic hit;
		array_index_t index;
	} array_map_t;
	// folds the three mapped regions onto one dense index
	function automatic array_map_t mapAddr(input eprom_addr_t a);
		array_map_t m;
		m.hit = 1'b0;
		m.index = '0;
		if (a >= `MAIN_FIRST && a <= `MAIN_LAST) begin
			m.hit = 1'b1;
			m.index = a - `MAIN_FIRST;
		end else if (a == `OPTION_ADDR) begin
			m.hit = 1'b1;
			m.index = `MAIN_BYTES;
		end else if (a >= `VECTOR_FIRST) begin
			m.hit = 1'b1;
			m.index = 15'(`MAIN_BYTES + 15'h0001 + (a - `VECTOR_FIRST));
		end
		return m;
	endfunction
endpackage

// ---- verification/eprom_read_program_control_tb_top.sv ----
`include "eprom_ctl_defines.svh"
module eprom_read_program_control_tb_top
	import eprom_ctl_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	logic sys_clk = 1'b0;
	logic resetn = 1'b0;
	logic [17:0] awaddr = '0, araddr = '0;
	logic [31:0] wdata = '0, rdata;
	logic [1:0] bresp, rresp;
	logic awvalid = 1'b0, wvalid = 1'b0, arvalid = 1'b0;
	logic awready, wready, arready, bvalid, rvalid;
	logic bready = 1'b1, rready = 1'b1, stopEntry = 1'b0, switchCmd = 1'b0;
	logic supplyPin, vecAllow, bootAllow, readMode;
	int numErrors = 0;
	int nCompared = 0;

	// 10 MHz bus clock
	always #50 sys_clk = ~sys_clk;

	eprom_ctl u_eprom_ctl (.sys_clk(sys_clk), .resetn(resetn),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
		.stopEntry(stopEntry), .arraySupplyPin(supplyPin), .vectorFetchAllow(vecAllow),
		.bootRomAllow(bootAllow), .readMode(readMode));

	supply_switch_model u_supply_switch_model (.sys_clk(sys_clk), .resetn(resetn),
		.switchCmd(switchCmd), .arraySupplyPin(supplyPin));

	function automatic logic [17:0] byteAddr(input eprom_addr_t a);
		return {1'b0, a, 2'b00};
	endfunction

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		nCompared++;
		if (seen !== exp) begin
			numErrors++;
			$display("MISMATCH at %0t: seen 0x%h expected 0x%h", $time, seen, exp);
		end
	endtask

	// values seen at the falling edge are those taken at the next rising edge
	task automatic axiWrite(input logic [17:0] a, input logic [31:0] d, input logic [1:0] er);
		logic awr, wr, bv;
		logic [1:0] r;
		int n;
		n = 0;
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		do begin
			@(negedge sys_clk);
			awr = awready & awvalid;
			wr = wready & wvalid;
			bv = bvalid;
			r = bresp;
			@(posedge sys_clk);
			if (awr) awvalid <= 1'b0;
			if (wr) wvalid <= 1'b0;
			n++;
		end while (bv !== 1'b1 && n < 50);
		if (bv !== 1'b1) numErrors++;
		chk({30'h0, r}, {30'h0, er});
	endtask

	task automatic axiRead(input logic [17:0] a, output logic [31:0] d, output logic [1:0] r);
		logic ar, rv;
		int n;
		n = 0;
		araddr <= a;
		arvalid <= 1'b1;
		do begin
			@(negedge sys_clk);
			ar = arready & arvalid;
			rv = rvalid;
			d = rdata;
			r = rresp;
			@(posedge sys_clk);
			if (ar) arvalid <= 1'b0;
			n++;
		end while (rv !== 1'b1 && n < 50);
		if (rv !== 1'b1) numErrors++;
	endtask

	task automatic rdChk(input logic [17:0] a, input logic [31:0] exp, input logic [1:0] er);
		logic [31:0] d;
		logic [1:0] r;
		axiRead(a, d, r);
		chk({30'h0, r}, {30'h0, er});
		chk(d, exp);
	endtask

	// the routine runs from the bench, never from the array itself
	task automatic burn(input eprom_addr_t a0, input eprom_byte_t d0, input eprom_addr_t a1,
		input eprom_byte_t d1, input eprom_addr_t stray);
		logic [31:0] s;
		logic [1:0] r;
		int n;
		axiWrite(`CTRL_OFFSET, 32'h1, `RESP_OKAY);
		axiWrite(`CTRL_OFFSET, 32'h3, `RESP_OKAY);
		rdChk(`CTRL_OFFSET, 32'h1, `RESP_OKAY);
		axiWrite(byteAddr(a0), {24'h0, d0}, `RESP_OKAY);
		axiWrite(byteAddr(a1), {24'h0, d1}, `RESP_OKAY);
		axiWrite(byteAddr(stray), 32'hff, `RESP_OKAY);
		rdChk(`STATUS_OFFSET, 32'h1, `RESP_OKAY);
		rdChk(byteAddr(a0), {24'h0, `ERASED_BYTE}, `RESP_OKAY);
		axiWrite(`CTRL_OFFSET, 32'h3, `RESP_OKAY);
		axiWrite(`CTRL_OFFSET, 32'h1, `RESP_OKAY);
		rdChk(`CTRL_OFFSET, 32'h3, `RESP_OKAY);
		switchCmd <= 1'b1;
		n = 0;
		s = '0;
		while (s[1] !== 1'b1 && n < 60) begin
			axiRead(`STATUS_OFFSET, s, r);
			n++;
		end
		chk(s, 32'h7);
		switchCmd <= 1'b0;
		axiWrite(`CTRL_OFFSET, 32'h0, `RESP_OKAY);
		rdChk(`CTRL_OFFSET, 32'h0, `RESP_OKAY);
	endtask

	task automatic end_of_test();
		if (numErrors == 0 && nCompared > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	// main sequence
	initial begin
		logic [31:0] d;
		logic [1:0] r;
		repeat (12) @(posedge sys_clk);
		resetn <= 1'b1;
		@(negedge sys_clk);
		chk({29'h0, vecAllow, bootAllow, readMode}, 32'h7);
		@(posedge sys_clk);
		rdChk(byteAddr(`OPTION_ADDR), 32'h0, `RESP_OKAY);
		axiWrite(byteAddr(15'h7e00), 32'h1, `RESP_SLVERR);
		axiRead(byteAddr(15'h03ff), d, r);
		chk({30'h0, r}, {30'h0, `RESP_SLVERR});
		axiWrite(byteAddr(15'h0500), 32'h77, `RESP_OKAY);
		rdChk(byteAddr(15'h0500), 32'h0, `RESP_OKAY);
		burn(`MAIN_FIRST, 8'h81, 15'h040f, 8'h42, 15'h0410);
		rdChk(byteAddr(`MAIN_FIRST), 32'h81, `RESP_OKAY);
		rdChk(byteAddr(15'h040f), 32'h42, `RESP_OKAY);
		rdChk(byteAddr(15'h0410), 32'h0, `RESP_OKAY);
		rdChk(byteAddr(`MAIN_LAST), 32'h0, `RESP_OKAY);
		burn(`MAIN_FIRST, 8'h14, 15'h0405, 8'h33, `VECTOR_FIRST);
		rdChk(byteAddr(`MAIN_FIRST), 32'h95, `RESP_OKAY);
		rdChk(byteAddr(`VECTOR_FIRST), 32'h0, `RESP_OKAY);
		burn(`OPTION_ADDR, 8'h5a, `OPTION_ADDR, 8'h5a, 15'h7ffe);
		rdChk(byteAddr(`OPTION_ADDR), 32'h5a, `RESP_OKAY);
		rdChk(byteAddr(15'h7ffe), 32'h0, `RESP_OKAY);
		// stop entry while loading must fall back to read mode
		axiWrite(`CTRL_OFFSET, 32'h1, `RESP_OKAY);
		@(negedge sys_clk);
		chk({29'h0, vecAllow, bootAllow, readMode}, 32'h0);
		@(posedge sys_clk);
		stopEntry <= 1'b1;
		@(posedge sys_clk);
		stopEntry <= 1'b0;
		repeat (2) @(posedge sys_clk);
		@(negedge sys_clk);
		chk({29'h0, vecAllow, bootAllow, readMode}, 32'h7);
		@(posedge sys_clk);
		rdChk(`CTRL_OFFSET, 32'h0, `RESP_OKAY);
		// reset mid-run with latch set leaves the array as it was
		axiWrite(`CTRL_OFFSET, 32'h1, `RESP_OKAY);
		resetn <= 1'b0;
		repeat (3) @(posedge sys_clk);
		resetn <= 1'b1;
		@(posedge sys_clk);
		rdChk(`CTRL_OFFSET, 32'h0, `RESP_OKAY);
		rdChk(byteAddr(`OPTION_ADDR), 32'h5a, `RESP_OKAY);
		rdChk(byteAddr(`MAIN_FIRST), 32'h95, `RESP_OKAY);
		end_of_test();
	end

	// watchdog, well beyond the few hundred cycles the run needs
	initial begin
		#5000000;
		numErrors++;
		end_of_test();
	end
endmodule

// ---- verification/supply_switch_model.sv ----
module supply_switch_model #(
	parameter int RAMP_CYCLES = 3
) (
	// clock and reset
	input wire logic sys_clk,
	input wire logic resetn,
	// command pin from the programming routine
	input wire logic switchCmd,
	// programming supply level
	output logic arraySupplyPin
);
	timeunit 1ns;
	timeprecision 1ns;
	int rampCnt;

	// supply ramps up slowly but drops at once, no kinder than a real switch
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			rampCnt <= 0;
			arraySupplyPin <= 1'b0;
		end else if (!switchCmd) begin
			rampCnt <= 0;
			arraySupplyPin <= 1'b0;
		end else if (rampCnt < RAMP_CYCLES) begin
			rampCnt <= rampCnt + 1;
		end else begin
			arraySupplyPin <= 1'b1;
		end
	end
endmodule
